// *** hw/add_exec_pkg.sv ***
// Constants, register map and types of the add instruction execute block
package add_exec_pkg;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ACC_OFS    = 8'h04;
  localparam logic [7:0] FLAGS_OFS  = 8'h08;
  localparam logic [7:0] BANK_OFS   = 8'h0C;
  localparam logic [7:0] EXEC_OFS   = 8'h10;
  // Control bits
  localparam int CTRL_EXT_BIT  = 0;
  localparam int CTRL_PRES_BIT = 1;
  localparam int CTRL_W        = 2;
  // Flag positions in the status register
  localparam int FLAG_C   = 0;
  localparam int FLAG_DC  = 1;
  localparam int FLAG_Z   = 2;
  localparam int FLAG_OV  = 3;
  localparam int FLAG_N   = 4;
  localparam int FLAGS_W  = 5;
  // Instruction fields
  localparam logic [7:0] ADD_LIT_TOP    = 8'h0F;
  localparam logic [5:0] ADD_FILE_TOP   = 6'h09;
  localparam logic [3:0] SECOND_WORD    = 4'hF;
  localparam logic [5:0] TWO_WORD_TOP   = 6'h3B;
  localparam int         DEST_BIT       = 9;
  localparam int         ACCESS_BIT     = 8;
  localparam logic [7:0] INDEX_LIMIT    = 8'h5F;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  // Special file addresses
  localparam logic [11:0] TIMER_ZERO_ADDR = 12'hFD0;
  localparam logic [11:0] PORT_ADDR       = 12'hF80;
  localparam logic [11:0] PC_LOW_ADDR     = 12'hFF9;
  // Four phases of one instruction cycle, Gray ordered
  typedef enum logic [1:0] {PH_Q1 = 2'h0, PH_Q2 = 2'h1, PH_Q3 = 2'h3, PH_Q4 = 2'h2} phase_t;
endpackage

// *** hw/add_flags.sv ***
// Eight-bit adder with status flag generation
module add_flags (
  input  wire logic [7:0]                       a,
  input  wire logic [7:0]                       b,
  output logic      [7:0]                       sum,
  output logic      [add_exec_pkg::FLAGS_W-1:0] flags
);
  logic [8:0] full;
  logic [4:0] low;
  always_comb
  begin
    full = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    sum = full[7:0];
    flags = '0;
    flags[add_exec_pkg::FLAG_C] = full[8];
    flags[add_exec_pkg::FLAG_DC] = low[4];
    flags[add_exec_pkg::FLAG_Z] = (full[7:0] == 8'h00);
    // Signed overflow: like-signed operands giving a differently signed sum
    flags[add_exec_pkg::FLAG_OV] = (a[7] == b[7]) && (full[7] != a[7]);
    flags[add_exec_pkg::FLAG_N] = full[7];
  end
endmodule

// *** hw/add_instruction_execute.sv ***
// Four-phase execute unit for the add instructions with APB register access

module add_instruction_execute #(
  parameter logic [11:0] TIMER_ADDR = add_exec_pkg::TIMER_ZERO_ADDR,
  parameter logic [11:0] PIN_ADDR   = add_exec_pkg::PORT_ADDR,
  parameter logic [11:0] PCL_ADDR   = add_exec_pkg::PC_LOW_ADDR
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  output logic             instrTake,
  input  wire logic [11:0] indexBase,
  input  wire logic [7:0]  portPins,
  input  wire logic [7:0]  fileRdData,
  output logic      [11:0] fileAddr,
  output logic      [7:0]  fileWrData,
  output logic             fileWrEn,
  output logic             prescalerClear
);
  typedef struct packed {
    add_exec_pkg::phase_t              ph;
    logic [15:0]                       ir;
    logic                              irOk;
    logic                              nopNext;
    logic                              consume;
    logic [7:0]                        acc;
    logic [add_exec_pkg::FLAGS_W-1:0]  flags;
    logic [3:0]                        bank_select_reg;
    logic [add_exec_pkg::CTRL_W-1:0]   ctrl;
    logic [7:0]                        opnd;
    logic [7:0]                        sum;
    logic [add_exec_pkg::FLAGS_W-1:0]  sumFl;
    logic [11:0]                       fileAddr;
    logic [7:0]                        fileWrData;
    logic                              fileWrEn;
    logic                              presClear;
    logic                              instrTake;
    logic                              pready;
    logic                              pslverr;
    logic [31:0]                       prdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [7:0]                       aluSum;
  logic [add_exec_pkg::FLAGS_W-1:0] aluFlags;

  function automatic logic isAddLit(input logic [15:0] w);
    return w[15:8] == add_exec_pkg::ADD_LIT_TOP;
  endfunction

  function automatic logic isAddFile(input logic [15:0] w);
    return w[15:10] == add_exec_pkg::ADD_FILE_TOP;
  endfunction

  function automatic logic [11:0] fileAddrOf(input logic [15:0] w, input logic [3:0] bank,
                                              input logic ext, input logic [11:0] base);
    if (w[add_exec_pkg::ACCESS_BIT])
      return {bank, w[7:0]};
    else if (ext && w[7:0] <= add_exec_pkg::INDEX_LIMIT)
      return 12'(base + {4'h0, w[7:0]});
    else if (w[7:0] <= add_exec_pkg::INDEX_LIMIT)
      return {add_exec_pkg::ACCESS_LO_BANK, w[7:0]};
    else
      return {add_exec_pkg::ACCESS_HI_BANK, w[7:0]};
  endfunction

  add_flags u_add (
    .a     (st_r.acc),
    .b     (st_r.opnd),
    .sum   (aluSum),
    .flags (aluFlags)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.fileWrEn = 1'b0;
    st_nxt.presClear = 1'b0;
    st_nxt.instrTake = 1'b0;
    // APB: one wait state, the access completes on the second penable edge
    st_nxt.pready = psel && penable && !st_r.pready;
    if (psel && penable && !st_r.pready)
    begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h0000_0000;
      case (paddr)
        add_exec_pkg::CTRL_OFS:  st_nxt.prdata[add_exec_pkg::CTRL_W-1:0] = st_r.ctrl;
        add_exec_pkg::ACC_OFS:   st_nxt.prdata[7:0] = st_r.acc;
        add_exec_pkg::FLAGS_OFS: st_nxt.prdata[add_exec_pkg::FLAGS_W-1:0] = st_r.flags;
        add_exec_pkg::BANK_OFS:  st_nxt.prdata[3:0] = st_r.bank_select_reg;
        add_exec_pkg::EXEC_OFS:  st_nxt.prdata[4:0] = {st_r.consume, st_r.nopNext, st_r.irOk, st_r.ph};
        default:                 st_nxt.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && st_r.pready && pwrite)
    begin
      case (paddr)
        add_exec_pkg::CTRL_OFS:  st_nxt.ctrl = pwdata[add_exec_pkg::CTRL_W-1:0];
        add_exec_pkg::ACC_OFS:   st_nxt.acc = pwdata[7:0];
        add_exec_pkg::FLAGS_OFS: st_nxt.flags = pwdata[add_exec_pkg::FLAGS_W-1:0];
        add_exec_pkg::BANK_OFS:  st_nxt.bank_select_reg = pwdata[3:0];
        default:                 st_nxt.ctrl = st_nxt.ctrl;
      endcase
    end
    // Core phases; a core write in Q4 overrides a same-edge APB write
    case (st_r.ph)
      add_exec_pkg::PH_Q1:
      begin
        st_nxt.ph = add_exec_pkg::PH_Q2;
        st_nxt.irOk = 1'b0;
        if (st_r.nopNext)
          st_nxt.nopNext = 1'b0;
        else if (instrValid)
        begin
          st_nxt.instrTake = 1'b1;
          st_nxt.ir = instrWord;
          // Absorbed second word or a lone 1111 word does nothing
          st_nxt.consume = !st_r.consume && instrWord[15:10] == add_exec_pkg::TWO_WORD_TOP;
          st_nxt.irOk = !st_r.consume && instrWord[15:12] != add_exec_pkg::SECOND_WORD
                        && (isAddLit(instrWord) || isAddFile(instrWord));
          st_nxt.fileAddr = fileAddrOf(instrWord, st_r.bank_select_reg, st_r.ctrl[add_exec_pkg::CTRL_EXT_BIT], indexBase);
        end
      end
      add_exec_pkg::PH_Q2:
      begin
        st_nxt.ph = add_exec_pkg::PH_Q3;
        if (isAddLit(st_r.ir))
          st_nxt.opnd = st_r.ir[7:0];
        else if (st_r.fileAddr == PIN_ADDR)
          st_nxt.opnd = portPins;
        else
          st_nxt.opnd = fileRdData;
      end
      add_exec_pkg::PH_Q3:
      begin
        st_nxt.ph = add_exec_pkg::PH_Q4;
        st_nxt.sum = aluSum;
        st_nxt.sumFl = aluFlags;
      end
      add_exec_pkg::PH_Q4:
      begin
        st_nxt.ph = add_exec_pkg::PH_Q1;
        if (st_r.irOk)
        begin
          st_nxt.flags = st_r.sumFl;
          if (isAddLit(st_r.ir) || !st_r.ir[add_exec_pkg::DEST_BIT])
            st_nxt.acc = st_r.sum;
          else
          begin
            st_nxt.fileWrEn = 1'b1;
            st_nxt.fileWrData = st_r.sum;
            st_nxt.presClear = st_r.fileAddr == TIMER_ADDR && st_r.ctrl[add_exec_pkg::CTRL_PRES_BIT];
            st_nxt.nopNext = st_r.fileAddr == PCL_ADDR;
          end
        end
      end
      default: st_nxt.ph = add_exec_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign instrTake = st_r.instrTake;
  assign fileAddr = st_r.fileAddr;
  assign fileWrData = st_r.fileWrData;
  assign fileWrEn = st_r.fileWrEn;
  assign prescalerClear = st_r.presClear;

  pin_operand_a: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.ph == add_exec_pkg::PH_Q2 && !isAddLit(st_r.ir) && st_r.fileAddr == PIN_ADDR)
    |=> st_r.opnd == $past(portPins)) else $error("port operand not taken from pins");
  presc_clear_a: assert property (@(posedge clk) disable iff (srst)
    prescalerClear |-> fileWrEn && fileAddr == TIMER_ADDR && st_r.ctrl[add_exec_pkg::CTRL_PRES_BIT])
    else $error("prescaler clear without timer write");
  pc_nop_a: assert property (@(posedge clk) disable iff (srst)
    (fileWrEn && fileAddr == PCL_ADDR && ce) |=> !st_r.irOk ##0 !instrTake)
    else $error("pc write not followed by nop cycle");
  lone_second_a: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.ph == add_exec_pkg::PH_Q1 && !st_r.nopNext && instrValid
     && instrWord[15:12] == add_exec_pkg::SECOND_WORD) |=> !st_r.irOk)
    else $error("second word executed");
  lit_result_a: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.ph == add_exec_pkg::PH_Q4 && st_r.irOk && isAddLit(st_r.ir))
    |=> st_r.acc == $past(st_r.sum) && st_r.flags == $past(st_r.sumFl))
    else $error("literal add result lost");
  dest_file_a: assert property (@(posedge clk) disable iff (srst)
    fileWrEn |-> st_r.ir[add_exec_pkg::DEST_BIT] && isAddFile(st_r.ir) && fileWrData == st_r.sum)
    else $error("file write with wrong destination");
  bank_sel_a: assert property (@(posedge clk) disable iff (srst)
    (st_r.ph == add_exec_pkg::PH_Q2 && $past(st_r.ph) == add_exec_pkg::PH_Q1 && st_r.irOk && isAddFile(st_r.ir)
     && st_r.ir[add_exec_pkg::ACCESS_BIT]) |-> fileAddr == {$past(st_r.bank_select_reg), st_r.ir[7:0]})
    else $error("banked address wrong");
  index_mode_a: assert property (@(posedge clk) disable iff (srst)
    (st_r.ph == add_exec_pkg::PH_Q2 && st_r.irOk && !st_r.ir[add_exec_pkg::ACCESS_BIT]
     && st_r.ir[7:0] > add_exec_pkg::INDEX_LIMIT) |-> fileAddr == {add_exec_pkg::ACCESS_HI_BANK, st_r.ir[7:0]})
    else $error("high access address indexed");
  phase_seq_a: assert property (@(posedge clk) disable iff (srst)
    (ce && st_r.ph == add_exec_pkg::PH_Q1) |=> (!ce || st_r.ph == add_exec_pkg::PH_Q2))
    else $error("phase order broken");
endmodule

// *** testbench/test_add_instruction_execute.sv ***
// Self-checking bench of the add instruction execute block
module test_add_instruction_execute;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instrValid = 1'b0;
  logic [7:0]  paddr = 8'h00, portPins = 8'h00, fileRdData = 8'h00, fileWrData, acc = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'h13;
  logic [15:0] instrWord = 16'h0000;
  logic [11:0] indexBase = 12'h000, fileAddr;
  logic        pready, pslverr, instrTake, fileWrEn, prescalerClear, err, skip = 1'b0, ce = 1'b1;
  logic [4:0]  flg = 5'h00;
  logic [3:0]  bank = 4'h0;
  logic [1:0]  ctrl = 2'h0;
  logic [7:0]  cf [6] = '{8'h5F, 8'h60, 8'hF9, 8'h80, 8'hD0, 8'h00};
  int          err_total = 0, comparisons = 0, cyc = 0, n, ptake = 0;

  // ce is dropped once near the end to check that the core freezes
  add_instruction_execute add_instruction_execute_inst (
    .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instrWord(instrWord), .instrValid(instrValid), .instrTake(instrTake), .indexBase(indexBase),
    .portPins(portPins), .fileRdData(fileRdData), .fileAddr(fileAddr), .fileWrData(fileWrData),
    .fileWrEn(fileWrEn), .prescalerClear(prescalerClear));

  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Returns flags above the eight-bit sum
  function automatic logic [12:0] sumf(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] f;
    s = {1'b0, a} + {1'b0, b};
    f = 5'h00;
    f[add_exec_pkg::FLAG_C] = s[8];
    f[add_exec_pkg::FLAG_DC] = s[4] ^ a[4] ^ b[4];
    f[add_exec_pkg::FLAG_Z] = s[7:0] == 8'h00;
    f[add_exec_pkg::FLAG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
    f[add_exec_pkg::FLAG_N] = s[7];
    return {f, s[7:0]};
  endfunction

  function automatic logic [11:0] eaddr(input logic [7:0] f, input logic a);
    if (a)
      return {bank, f};
    if (ctrl[0] && f <= add_exec_pkg::INDEX_LIMIT)
      return indexBase + {4'h0, f};
    return {(f <= add_exec_pkg::INDEX_LIMIT) ? 4'h0 : 4'hF, f};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Waits on pready with no assumed latency; phase alignment is lost meanwhile
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ptake = 0;
  endtask

  task automatic exe(input logic [15:0] w, input logic [7:0] fr, input logic [7:0] pins);
    logic        isf, isl, d, pcw, offer, pre;
    logic [11:0] ea;
    logic [12:0] r;
    isf = w[15:10] == add_exec_pkg::ADD_FILE_TOP && !skip;
    isl = w[15:8] == add_exec_pkg::ADD_LIT_TOP && !skip;
    d = w[add_exec_pkg::DEST_BIT];
    ea = eaddr(w[7:0], w[add_exec_pkg::ACCESS_BIT]);
    pcw = isf && d && ea == add_exec_pkg::PC_LOW_ADDR;
    pre = isf && d && ea == add_exec_pkg::TIMER_ZERO_ADDR && ctrl[1];
    offer = !(w[15:10] == add_exec_pkg::TWO_WORD_TOP && !skip);
    r = sumf(acc, isf ? ((ea == add_exec_pkg::PORT_ADDR) ? pins : fr) : w[7:0]);
    @(posedge clk);
    instrWord <= w;
    instrValid <= 1'b1;
    fileRdData <= fr;
    portPins <= pins;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (instrTake !== 1'b1);
    if (ptake != 0)
      chk("take delay", ptake, n);
    instrValid <= 1'b0;
    repeat (2) @(posedge clk);
    // Filler word before the next Q1 edge: it waits out a forced no-operation only after a PC low write
    instrWord <= 16'h0000;
    instrValid <= offer;
    @(posedge clk);
    instrValid <= 1'b0;
    chk("write enable", 32'(isf && d), 32'(fileWrEn));
    chk("prescaler clear", 32'(pre), 32'(prescalerClear));
    if (isf)
      chk("file address", 32'(ea), 32'(fileAddr));
    if (isf && d)
      chk("file data", 32'(r[7:0]), 32'(fileWrData));
    @(posedge clk);
    chk("filler take", 32'(offer && !pcw), 32'(instrTake));
    if ((isf && !d) || isl)
      acc = r[7:0];
    if (isf || isl)
      flg = r[12:8];
    // Next word goes up two edges before the Q1 edge that takes it, so instrTake shows on the third
    ptake = 3;
    skip = w[15:10] == add_exec_pkg::TWO_WORD_TOP && !skip;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk("reset value", 32'h0, rd);
      chk("bus error", 32'h0, {31'h0, err});
    end
    apb(1'b0, add_exec_pkg::EXEC_OFS, 32'h0);
    chk("exec status", 32'h0, rd & 32'hFFFF_FFFC);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    for (int i = 0; i < 60; i++)
    begin
      v = rnd();
      ctrl = (i < 6) ? 2'h3 : v[1:0];
      bank = v[5:2];
      indexBase <= v[17:6];
      apb(1'b1, add_exec_pkg::CTRL_OFS, {30'h0, ctrl});
      apb(1'b1, add_exec_pkg::BANK_OFS, {28'h0, bank});
      apb(1'b1, add_exec_pkg::ACC_OFS, {24'h0, v[31:24]});
      acc = v[31:24];
      v = rnd();
      exe({6'h09, v[9] | (i < 6), v[8] & (i >= 30), (i < 30) ? cf[i % 6] : v[7:0]}, v[23:16], v[31:24]);
      v = rnd();
      exe({8'h0F, v[7:0]}, v[15:8], v[23:16]);
      apb(1'b0, add_exec_pkg::ACC_OFS, 32'h0);
      chk("accumulator", {24'h0, acc}, rd);
      apb(1'b0, add_exec_pkg::FLAGS_OFS, 32'h0);
      chk("flags", {27'h0, flg}, rd);
    end
    // Second word of a pair is absorbed; a lone one is inert
    exe(16'hEC12, 8'h00, 8'h00);
    exe(16'h0F05, 8'h00, 8'h00);
    exe(16'hF0AB, 8'h00, 8'h00);
    // Clock enable low freezes the core: a word offered meanwhile is never taken
    @(posedge clk);
    ce <= 1'b0;
    instrWord <= 16'h0F10;
    instrValid <= 1'b1;
    repeat (8)
    begin
      @(posedge clk);
      chk("frozen take", 32'h0, 32'(instrTake));
    end
    instrValid <= 1'b0;
    ce <= 1'b1;
    ptake = 0;
    exe(16'h0F01, 8'h00, 8'h00);
    apb(1'b0, add_exec_pkg::ACC_OFS, 32'h0);
    chk("accumulator", {24'h0, acc}, rd);
    complete_run();
  end
endmodule
